/* File: verilog/vlp_pkg.sv */
// Purpose : constants for the video lookup, pan and zoom path
// Assumes : 8 planes, parcels of 16 or 20 bits, 256 x 24 colour map
// Notes   : register offsets are byte addresses on the plain register port
package vlp_pkg;
  localparam int NPLANE     = 8;
  localparam int PARCEL_MAX = 20;
  localparam int PARCEL_W   = NPLANE * PARCEL_MAX;
  localparam logic [4:0] LEN_NARROW = 5'd16;
  localparam logic [4:0] LEN_WIDE   = 5'd20;
  localparam logic [4:0] FOLD_STEP  = 5'd4;
  localparam int FIFO_DEPTH = 16;
  // register offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_MASK   = 8'h04;
  localparam logic [7:0] OFF_ZOOM   = 8'h08;
  localparam logic [7:0] OFF_PAN    = 8'h0C;
  localparam logic [7:0] OFF_XBAR   = 8'h10;
  localparam logic [7:0] OFF_MAPIDX = 8'h14;
  localparam logic [7:0] OFF_MAPDAT = 8'h18;
  localparam logic [7:0] OFF_SIG    = 8'h1C;
  localparam logic [7:0] OFF_LED    = 8'h20;
  localparam logic [7:0] OFF_STAT   = 8'h24;
  // control and status field positions
  localparam int CTRL_FOLD = 0;
  localparam int CTRL_FOUR = 1;
  localparam int CTRL_WIDE = 2;
  localparam int STAT_UNDER = 2;
  // reset values and crc polynomial
  localparam logic [7:0]  MASK_RST = 8'hFF;
  localparam logic [5:0]  XBAR_RST = 6'h24;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
endpackage

/* File: verilog/vlp_video_path.sv */
// Purpose : video path: parcel fifo, shifters, crossbar, pan, zoom, map, signature
// Assumes : sync and active inputs come from logic on clk
// Notes   : map lookup is combinational from the array, then registered
//
// Behaviour
// - folded mode: four 8-bit banks per pixel, one bit from each plane
// - crossbar routes any bank to any input
// - zoom prescaler slows shifters and horizontal refresh counter
// - refresh counters start from loaded pan address
// - horizontal counter steps once per parcel loaded
// - fine offset gives single pixel pan
// - colour map 256 x 24 readable writable
// - eight planes form 8-bit map address
// - four-plane mode gives 4-bit address
// - map word split into 8-bit rgb
// - map rewrites take effect on later pixels
// - composite sync on green, separate syncs in wide mode only
// - crc signature over map output
// - signature readable by command read
// - led register drives led indicator
// - plane shifters load 16 or 20-bit parcels
// - read mask blocks any plane
`timescale 1ns/1ns

// ----------------------------------------------------------------
// parcel fifo
// ----------------------------------------------------------------
module vlp_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic [W-1:0] inData,
  input  wire logic         inValid,
  output logic              inReady,
  output logic [W-1:0]      outData,
  output logic              outValid,
  input  wire logic         outReady
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0]   count_reg;
  logic          push;
  logic          pop;

  // handshake terms
  assign inReady  = (count_reg != (AW+1)'(D));
  assign outValid = (count_reg != '0);
  assign push     = ce && inValid && inReady;
  assign pop      = ce && outValid && outReady;
  assign outData  = mem[rdPtr_reg];

  // storage
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_reg <= wrPtr_reg + AW'(1);
      end
      if (pop)
      begin
        rdPtr_reg <= rdPtr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ----------------------------------------------------------------
// top of the path
// ----------------------------------------------------------------
module vlp_video_path (
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  input  wire logic                         ce,
  input  wire logic [7:0]                   regAddr,
  input  wire logic [31:0]                  regWrData,
  input  wire logic                         regWr,
  input  wire logic                         regRd,
  output logic [31:0]                       regRdData,
  input  wire logic [vlp_pkg::PARCEL_W-1:0] parcelData,
  input  wire logic                         parcelValid,
  output logic                              parcelReady,
  input  wire logic                         hSyncIn,
  input  wire logic                         vSyncIn,
  input  wire logic                         activeIn,
  output logic [11:0]                       refreshX,
  output logic [11:0]                       refreshY,
  output logic [7:0]                        dacRed,
  output logic [7:0]                        dacGreen,
  output logic [7:0]                        dacBlue,
  output logic                              greenSync,
  output logic                              hSyncOut,
  output logic                              vSyncOut,
  output logic [7:0]                        ledStatus
);
  import vlp_pkg::*;

  typedef logic [NPLANE-1:0][PARCEL_MAX-1:0] vlp_shift_t;

  typedef struct packed {
    logic                folded;
    logic                fourPlane;
    logic                wide;
    logic [7:0]          readMask;
    logic [3:0]          zoom;
    logic [4:0]          fineOff;
    logic [11:0]         panX;
    logic [11:0]         panY;
    logic [5:0]          xbar;
    logic [7:0]          mapIdx;
    logic [7:0]          led;
    vlp_shift_t          shift;
    logic [4:0]          bitCnt;
    logic [3:0]          zoomCnt;
    logic                firstLoad;
    logic [11:0]         refX;
    logic [11:0]         refY;
    logic                hsPrev;
    logic                vsPrev;
    logic [2:0][7:0]     lane;
    logic                s1Act;
    logic                s1Hs;
    logic                s1Vs;
    logic [23:0]         rgb;
    logic                s2Hs;
    logic                s2Vs;
    logic [15:0]         crc;
    logic [15:0]         sigHold;
    logic                sigValid;
    logic                sawFrame;
    logic                underrun;
    logic [31:0]         rdData;
  } vlp_state_s;

  vlp_state_s st_reg;
  vlp_state_s st_next;
  logic [23:0] cmap [256];
  logic [PARCEL_W-1:0] fifoData;
  logic fifoValid;
  logic fifoPop;

  // parcel buffer between refresh controller and shifters
  vlp_fifo #(.W(PARCEL_W), .D(FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .inData   (parcelData),
    .inValid  (parcelValid),
    .inReady  (parcelReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  // parallel crc over one 24-bit colour word
  function automatic logic [15:0] crc24(input logic [15:0] c, input logic [23:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 23; i >= 0; i--)
    begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    end
    return r;
  endfunction

  // colour map storage, written from the register port
  always_ff @(posedge clk)
  begin
    if (ce && regWr && regAddr == OFF_MAPDAT)
    begin
      cmap[st_reg.mapIdx] <= regWrData[23:0];
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [4:0]  len;
    logic [4:0]  step;
    logic        lineStart;
    logic        frameStart;
    logic        needLoad;
    logic        tick;
    vlp_shift_t  src;
    logic [4:0]  srcCnt;
    logic [3:0][7:0] bank;
    logic [7:0]  msk;
    logic [23:0] colour;
    st_next    = st_reg;
    len        = st_reg.wide ? LEN_WIDE : LEN_NARROW;
    step       = st_reg.folded ? FOLD_STEP : 5'd1;
    lineStart  = hSyncIn && !st_reg.hsPrev;
    frameStart = vSyncIn && !st_reg.vsPrev;
    needLoad   = activeIn && (st_reg.bitCnt < step);
    tick       = activeIn && (st_reg.zoomCnt == st_reg.zoom);
    fifoPop    = needLoad;
    src        = st_reg.shift;
    srcCnt     = st_reg.bitCnt;
    bank       = '0;
    colour     = 24'h000000;
    msk        = st_reg.readMask & (st_reg.fourPlane ? 8'h0F : 8'hFF);
    st_next.hsPrev = hSyncIn;
    st_next.vsPrev = vSyncIn;
    // parcel load, left aligned, fine offset on the first of a line
    if (needLoad)
    begin
      srcCnt = fifoValid ? len : 5'd0;
      for (int p = 0; p < NPLANE; p++)
      begin
        src[p] = fifoValid ? (st_reg.wide ? fifoData[p*PARCEL_MAX +: PARCEL_MAX]
                 : {fifoData[p*PARCEL_MAX +: 16], 4'h0}) : '0;
      end
      if (st_reg.firstLoad && fifoValid)
      begin
        for (int p = 0; p < NPLANE; p++)
        begin
          src[p] = src[p] << st_reg.fineOff;
        end
        srcCnt = len - st_reg.fineOff;
        st_next.firstLoad = 1'b0;
      end
      if (fifoValid)
      begin
        st_next.refX = st_reg.refX + 12'd1;
      end
      else
      begin
        st_next.underrun = 1'b1;
      end
    end
    // banks: one bit from each plane per serial position
    for (int b = 0; b < 4; b++)
    begin
      for (int p = 0; p < NPLANE; p++)
      begin
        bank[b][p] = src[p][PARCEL_MAX-1-b] & msk[p];
      end
    end
    // crossbar to the three map inputs
    for (int k = 0; k < 3; k++)
    begin
      st_next.lane[k] = st_reg.folded ? bank[st_reg.xbar[2*k +: 2]] : bank[0];
    end
    st_next.s1Act = activeIn;
    st_next.s1Hs  = hSyncIn;
    st_next.s1Vs  = vSyncIn;
    // shift on the zoom tick only, so pixels repeat
    st_next.shift  = src;
    st_next.bitCnt = srcCnt;
    if (tick)
    begin
      st_next.zoomCnt = 4'd0;
      if (srcCnt >= step)
      begin
        for (int p = 0; p < NPLANE; p++)
        begin
          st_next.shift[p] = src[p] << step;
        end
        st_next.bitCnt = srcCnt - step;
      end
    end
    else if (activeIn)
    begin
      st_next.zoomCnt = st_reg.zoomCnt + 4'd1;
    end
    // line and frame starts reload the refresh counters
    if (lineStart)
    begin
      st_next.bitCnt    = 5'd0;
      st_next.zoomCnt   = 4'd0;
      st_next.firstLoad = 1'b1;
      st_next.refX      = st_reg.panX;
      st_next.refY      = st_reg.refY + 12'd1;
    end
    // map lookup, rgb split
    if (st_reg.folded)
    begin
      colour = {cmap[st_reg.lane[0]][23:16], cmap[st_reg.lane[1]][15:8],
                cmap[st_reg.lane[2]][7:0]};
    end
    else
    begin
      colour = cmap[st_reg.lane[0]];
    end
    st_next.rgb  = st_reg.s1Act ? colour : 24'h000000;
    st_next.s2Hs = st_reg.s1Hs;
    st_next.s2Vs = st_reg.s1Vs;
    // signature: accumulate active pixels, latch and clear per frame
    if (st_reg.s1Act)
    begin
      st_next.crc = crc24(st_reg.crc, colour);
    end
    if (frameStart)
    begin
      st_next.refY     = st_reg.panY;
      st_next.crc      = CRC_SEED;
      st_next.sigHold  = st_reg.crc;
      st_next.sigValid = st_reg.sawFrame;
      st_next.sawFrame = 1'b1;
    end
    // register writes
    if (regWr)
    begin
      unique case (regAddr)
        OFF_CTRL:
        begin
          st_next.folded    = regWrData[CTRL_FOLD];
          st_next.fourPlane = regWrData[CTRL_FOUR];
          st_next.wide      = regWrData[CTRL_WIDE];
        end
        OFF_MASK:   st_next.readMask = regWrData[7:0];
        OFF_ZOOM:   st_next.zoom     = regWrData[3:0];
        OFF_PAN:
        begin
          st_next.fineOff = regWrData[28:24] % len;
          st_next.panX    = regWrData[11:0];
          st_next.panY    = regWrData[23:12];
        end
        OFF_XBAR:   st_next.xbar     = regWrData[5:0];
        OFF_MAPIDX: st_next.mapIdx   = regWrData[7:0];
        OFF_LED:    st_next.led      = regWrData[7:0];
        OFF_STAT:
        begin
          if (regWrData[STAT_UNDER] && !(needLoad && !fifoValid))
          begin
            st_next.underrun = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end
    // register reads, answered in the next cycle
    st_next.rdData = 32'h00000000;
    if (regRd)
    begin
      unique case (regAddr)
        OFF_CTRL:   st_next.rdData = {29'h0, st_reg.wide, st_reg.fourPlane, st_reg.folded};
        OFF_MASK:   st_next.rdData = {24'h0, st_reg.readMask};
        OFF_ZOOM:   st_next.rdData = {28'h0, st_reg.zoom};
        OFF_PAN:    st_next.rdData = {3'h0, st_reg.fineOff, st_reg.panY, st_reg.panX};
        OFF_XBAR:   st_next.rdData = {26'h0, st_reg.xbar};
        OFF_MAPIDX: st_next.rdData = {24'h0, st_reg.mapIdx};
        OFF_MAPDAT: st_next.rdData = {8'h00, cmap[st_reg.mapIdx]};
        OFF_SIG:    st_next.rdData = {16'h0000, st_reg.sigHold};
        OFF_LED:    st_next.rdData = {24'h0, st_reg.led};
        OFF_STAT:   st_next.rdData = {28'h0, st_reg.sigValid, st_reg.underrun,
                                      !parcelReady, !fifoValid};
        default:    st_next.rdData = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg          <= '0;
      st_reg.readMask <= MASK_RST;
      st_reg.xbar     <= XBAR_RST;
      st_reg.crc      <= CRC_SEED;
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign regRdData = st_reg.rdData;
  assign refreshX  = st_reg.refX;
  assign refreshY  = st_reg.refY;
  assign dacRed    = st_reg.rgb[23:16];
  assign dacGreen  = st_reg.rgb[15:8];
  assign dacBlue   = st_reg.rgb[7:0];
  assign greenSync = st_reg.s2Hs | st_reg.s2Vs;
  assign hSyncOut  = st_reg.wide & st_reg.s2Hs;
  assign vSyncOut  = st_reg.wide & st_reg.s2Vs;
  assign ledStatus = st_reg.led;
endmodule

/* File: verif/vlp_video_path_chk.sv */
// Purpose: port assertions for the video path
// Assumes: one clock, syncs and strobes sampled on clk
// Notes  : wide bit mirrored from control writes
`timescale 1ns/1ns
module vlp_video_path_chk
  import vlp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        ce,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdData,
  input wire logic        hSyncIn,
  input wire logic        vSyncIn,
  input wire logic        activeIn,
  input wire logic [11:0] refreshX,
  input wire logic [11:0] refreshY,
  input wire logic [7:0]  dacRed,
  input wire logic [7:0]  dacGreen,
  input wire logic [7:0]  dacBlue,
  input wire logic        greenSync,
  input wire logic        hSyncOut,
  input wire logic        vSyncOut,
  input wire logic [7:0]  ledStatus
);
  logic       wideQ;
  logic [3:0] wideH;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence ledWr;
    ce && regWr && regAddr == OFF_LED;
  endsequence
  // ----------------------------------------
  // wide mode history
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wideQ <= 1'b0;
      wideH <= 4'h0;
    end
    else
    begin
      if (ce && regWr && regAddr == OFF_CTRL)
        wideQ <= regWrData[CTRL_WIDE];
      wideH <= {wideH[2:0], wideQ};
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  rd_idle_a: assert property (!$past(ce && regRd) |-> regRdData == 32'h0)
    else $error("read data outside answer cycle");
  black_idle_a: assert property (
    !$past(activeIn, 2) |-> {dacRed, dacGreen, dacBlue} == 24'h0)
    else $error("colour outside active time");
  gsync_comp_a: assert property (greenSync == $past(hSyncIn || vSyncIn, 2))
    else $error("composite sync wrong");
  // current wide bit included, since the sync gate follows it at once
  sep_off_a: assert property ({wideH, wideQ} == 5'h00 |-> !(hSyncOut || vSyncOut))
    else $error("separate sync in narrow mode");
  sep_on_a: assert property (
    {wideH, wideQ} == 5'h1F |-> hSyncOut == $past(hSyncIn, 2) && vSyncOut == $past(vSyncIn, 2))
    else $error("separate sync wrong");
  refx_step_a: assert property (
    $changed(refreshX) && !$past(hSyncIn) |-> refreshX == $past(refreshX) + 12'h1)
    else $error("refresh x not one parcel step");
  refy_sync_a: assert property ($changed(refreshY) |-> $past(hSyncIn || vSyncIn))
    else $error("refresh y moved without sync");
  led_load_a: assert property (ledWr |=> ledStatus == $past(regWrData[7:0]))
    else $error("led value not loaded");
  led_hold_a: assert property (
    !$past(ce && regWr && regAddr == OFF_LED) |-> $stable(ledStatus))
    else $error("led value changed");
endmodule
bind vlp_video_path vlp_video_path_chk vlp_video_path_chk_i (.*);

/* File: verif/vlp_refresh_model.sv */
// Purpose: refresh side: parcel stream and raster timing
// Assumes: 80-cycle lines, 6-line frames, 38 active cycles
// Notes  : parcels alternate between a seed and its inverse
`timescale 1ns/1ns
module vlp_refresh_model (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    feed,
  input  wire logic                    parcelReady,
  output logic [vlp_pkg::PARCEL_W-1:0] parcelData,
  output logic                         parcelValid,
  output logic                         hSyncIn,
  output logic                         vSyncIn,
  output logic                         activeIn
);
  import vlp_pkg::*;
  localparam logic [PARCEL_W-1:0] SEED = 160'h3C5A9E1F076B2D408F1CA7E355D0B8C92461F6A3;
  logic [6:0] col;
  logic [2:0] line;
  // raster decoded from the counters
  assign hSyncIn     = col < 7'h04;
  assign vSyncIn     = line == 3'h0 && col >= 7'h08 && col < 7'h0C;
  assign activeIn    = line >= 3'h1 && line <= 3'h4 && col >= 7'h14 && col < 7'h3A;
  assign parcelValid = feed;
  // counters free running, stream held while refused
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      col <= 7'h4F;
      line <= 3'h5;
      parcelData <= SEED;
    end
    else
    begin
      col <= (col == 7'h4F) ? 7'h00 : col + 7'h01;
      if (col == 7'h4F)
        line <= (line == 3'h5) ? 3'h0 : line + 3'h1;
      if (feed && parcelReady)
        parcelData <= ~parcelData;
    end
  end
endmodule

/* File: verif/vlp_video_path_tb_top.sv */
// Purpose: self-checking bench for the video path
// Assumes: map entry i holds {i, ~i, i ^ key}
// Notes  : pixel monitor checks the colour relation
`timescale 1ns/1ns
module vlp_video_path_tb_top;
  import vlp_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic feed = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic mon = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic [7:0] em = 8'hFF;
  logic [7:0] key = 8'h5A;
  logic [PARCEL_W-1:0] parcelData;
  logic parcelValid, parcelReady, hSyncIn, vSyncIn, activeIn;
  logic greenSync, hSyncOut, vSyncOut;
  logic [11:0] refreshX, refreshY;
  logic [7:0] dacRed, dacGreen, dacBlue, ledStatus;
  logic [31:0] regRdData, rdv, s1;
  int error_cnt = 0;
  int check_count = 0;
  int pixCnt = 0;
  vlp_video_path vlp_video_path_i (.*);
  vlp_refresh_model vlp_refresh_model_i (.*);
  // ----------------------------------------
  // clock, tasks, monitor
  // ----------------------------------------
  initial
  begin
    forever #5 clk = ~clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    rdv = regRdData;
  endtask
  task frames(input int n);
    repeat (n) @(posedge vSyncIn);
    @(posedge clk);
  endtask
  task fill(input logic [7:0] k);
    for (int i = 0; i < 256; i++)
    begin
      wr(OFF_MAPIDX, i);
      wr(OFF_MAPDAT, {8'h00, 8'(i), ~8'(i), 8'(i) ^ k});
    end
  endtask
  // monitor pauses across a setting change
  task reconf(input logic [7:0] a, input logic [31:0] d, input logic [7:0] m, k);
    mon <= 1'b0;
    wr(a, d);
    em <= m;
    key <= k;
    frames(1);
    mon <= 1'b1;
    frames(1);
  endtask
  task probe(input logic [31:0] c, z, p, input logic [11:0] x);
    wr(OFF_CTRL, c);
    wr(OFF_ZOOM, z);
    wr(OFF_PAN, p);
    frames(1);
    @(posedge vSyncIn);
    @(negedge activeIn);
    repeat (3) @(posedge clk);
    chk(refreshX, x);
    chk(refreshY, p[23:12] + 12'h1);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // every lit pixel obeys the map fill
  always @(posedge clk)
  begin
    if (mon && {dacRed, dacGreen, dacBlue} !== 24'h0)
    begin
      pixCnt++;
      chk({dacGreen, dacBlue, dacRed & ~em}, {~dacRed, dacRed ^ key, 8'h00});
    end
  end
  // hang guard
  initial
  begin
    #300000;
    error_cnt++;
    wrap_up;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(OFF_MASK);
    chk(rdv, 32'(MASK_RST));
    rd(OFF_XBAR);
    chk(rdv, 32'(XBAR_RST));
    wr(8'h30, 32'hFFFFFFFF);
    rd(8'h30);
    chk(rdv, 32'h0);
    fill(8'h5A);
    rd(OFF_MAPDAT);
    chk(rdv, 32'h00FF00A5);
    wr(OFF_LED, 32'hC6);
    chk(ledStatus, 32'hC6);
    mon <= 1'b1;
    frames(2);
    rd(OFF_SIG);
    s1 = rdv;
    frames(1);
    rd(OFF_SIG);
    chk(rdv, s1);
    rd(OFF_STAT);
    chk(rdv[3], 1'b1);
    reconf(OFF_MASK, 32'h0F, 8'h0F, 8'h5A);
    rd(OFF_SIG);
    chk(rdv != s1, 1'b1);
    mon <= 1'b0;
    fill(8'hC3);
    reconf(OFF_MASK, 32'hFF, 8'hFF, 8'hC3);
    reconf(OFF_CTRL, 32'h2, 8'h0F, 8'hC3);
    wr(OFF_XBAR, 32'h0);
    reconf(OFF_CTRL, 32'h1, 8'hFF, 8'hC3);
    mon <= 1'b0;
    wr(OFF_XBAR, 32'(XBAR_RST));
    probe(32'h0, 32'h0, 32'h0, 12'h3);
    probe(32'h0, 32'h1, 32'h0, 12'h2);
    probe(32'h4, 32'h0, 32'h0, 12'h2);
    probe(32'h1, 32'h0, 32'h0, 12'hA);
    probe(32'h0, 32'h0, 32'h0C003005, 12'h9);
    chk(pixCnt != 0, 1'b1);
    feed <= 1'b0;
    frames(2);
    rd(OFF_STAT);
    chk(rdv[2:0], 3'h5);
    feed <= 1'b1;
    frames(1);
    wr(OFF_STAT, 32'h4);
    rd(OFF_STAT);
    chk(rdv[2:0], 3'h2);
    wrap_up;
  end
endmodule
